/* File: ssp_defines.svh */
/*
 * Constants of the sensor serial port: register addresses, reset values,
 * field positions and bit counts. Assumes nothing but a preprocessor.
 */
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_ADDR_STATUS  3'h0
`define SSP_ADDR_CONFIG  3'h1
`define SSP_ADDR_TEMP    3'h2
`define SSP_ADDR_ID      3'h3
`define SSP_ADDR_CRITICAL_LIMIT   3'h4
`define SSP_ADDR_HYST    3'h5
`define SSP_ADDR_THIGH   3'h6
`define SSP_ADDR_LOWER_LIMIT    3'h7

`define SSP_WIDE_MAP     8'hD4
`define SSP_CFG_RST      8'h00
`define SSP_CRITICAL_LIMIT_RST    16'h4980
`define SSP_HYST_RST     8'h05
`define SSP_THIGH_RST    16'h2000
`define SSP_LOWER_LIMIT_RST     16'h0500

`define SSP_CMD_RW       6
`define SSP_CMD_AHI      5
`define SSP_CMD_ALO      3
`define SSP_CFG_CMPMODE  4
`define SSP_CFG_OPHI     6
`define SSP_CFG_OPLO     5
`define SSP_OP_SHDN      2'h3
`define SSP_STAT_LO      4
`define SSP_STAT_HI      5
`define SSP_STAT_CRIT    6
`define SSP_HYST_SHIFT   7

`define SSP_CMD_LAST     5'h07
`define SSP_NARROW_LAST  5'h07
`define SSP_WIDE_LAST    5'h0F
`define SSP_ONES_LAST    6'h1F
`define SSP_ONES_MAX     6'h20

`endif

/* File: ssp_pkg.sv */
/*
 * Types shared by the sensor serial port files.
 * Assumes ssp_defines.svh for the numeric constants.
 */
`default_nettype none
package ssp_pkg;
	typedef enum logic [1:0] {
		SSP_ST_CMD  = 2'b01,
		SSP_ST_DATA = 2'b10
	} ssp_state_t;

	typedef struct packed {
		logic [7:0]  config_r;
		logic [15:0] critical_limit;
		logic [7:0]  hysteresis_amount;
		logic [15:0] upper_limit;
		logic [15:0] lower_limit;
	} ssp_cfg_t;
endpackage
`default_nettype wire

/* File: ssp_sync.sv */
/*
 * Two-flop level synchroniser, W bits wide.
 * Assumes each bit is a slow level or a toggle, never a multi-bit word.
 */
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
	parameter int W = 1
) (
	// destination clock
	input  wire logic         clk,
	// levels from the other domain
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage is read by the second stage only
	always_ff @(posedge clk) begin
		meta_q <= d;
		q      <= meta_q;
	end
endmodule
`default_nettype wire

/* File: ssp_sensor_port.sv */
/*
 * Serial register port and limit-alarm logic of a temperature sensor.
 * Assumes an SPI master drives sclk, cs_n and din (mode 3 or free-running sclk),
 * and a conversion engine on clk gives temp_value with a temp_valid pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
// Functional notes
// RULE_01: master opens with cs_n fall, command byte
// RULE_02: master keeps command bits 7,2,1,0 zero
// RULE_03: command bit 6: one read, zero write
// RULE_04: bits 5..3 address one register per transaction
// RULE_05: write 8/16 bits, sampled rising sclk
// RULE_06: master raises cs_n, new command per write
// RULE_07: read data driven from first falling edge
// RULE_08: master raises cs_n after read data
// RULE_09: cs_n frames; output enabled at its fall (dout_oe here rises only in the data phase of a read)
// RULE_10: works with cs_n tied low
// RULE_11: master idles sclk high, recommended only
// RULE_12: 32 ones on din reset the port
// RULE_13: that reset restores all registers
// RULE_14: master waits 500 us after that reset
// RULE_15: alarm on above upper or below lower
// RULE_16: interrupt mode is the reset default
// RULE_17: comparator mode releases past hysteresis band
// RULE_18: comparator mode keeps alarm through shutdown
// RULE_19: interrupt mode: any read clears alarm
// RULE_20: interrupt mode: shutdown clears alarm
// RULE_21: master bring-up: reset, read id, config, limits
// RULE_22: launch on falling, sample on rising sclk
// RULE_23: hysteresis: low four bits, whole degrees
// RULE_24: critical alarm above critical limit
// RULE_25: signed compares; critical follows same modes
// RULE_26: early cs_n rise drops write, expects command
module ssp_sensor_port
	import ssp_pkg::*;
#(
	parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
) (
	// system clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// conversion results
	input  wire logic [15:0] temp_value,
	input  wire logic        temp_valid,
	// serial link
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output var  logic        dout,
	output var  logic        dout_oe,
	// alarms, active high
	output var  logic        alarm_out,
	output var  logic        critical_alarm_out
);
	// link domain state
	ssp_state_t  state_q, state_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [14:0] sh_q, sh_d;
	logic        rw_q, rw_d;
	logic [2:0]  addr_q, addr_d;
	logic [5:0]  ones_q, ones_d;
	ssp_cfg_t    regs_q, regs_d;
	logic [15:0] temp_q, temp_d;
	logic [15:0] rd_word_q, rd_word_d;
	logic        tack_q, tack_d;
	logic [2:0]  tgl_q, tgl_d;   // {srst, cfg, rd}
	logic [15:0] out_sh_q;
	logic [4:0]  sync_s;
	logic        srst_s, treq_s;
	logic        srst_evt, wide, last;
	logic [7:0]  cmd;
	logic [15:0] word;

	// system domain state
	ssp_cfg_t    cfg_c_q, cfg_c_d;
	logic [2:0]  tgl_c, tgl_p_q;
	logic [15:0] hold_q, hold_d, meas_q, meas_d;
	logic        treq_q, treq_d, tack_c;
	logic [2:0]  cmp_q, cmp_d;   // {crit, hi, lo}
	logic [1:0]  int_q, int_d;   // {crit, main}
	logic        shdn_p_q, shdn_p_d;
	logic        alarm_q, alarm_d, crit_q, crit_d;
	logic        rd_evt, cfg_evt, srst_evt_c, shdn, cmp_mode;

	ssp_sync #(.W(5)) u_sync_s (
		.clk (sclk),
		.d   ({rst, treq_q, cmp_q}),
		.q   (sync_s)
	);
	assign srst_s = sync_s[4];
	assign treq_s = sync_s[3];

	localparam logic [7:0] WIDE_MAP = `SSP_WIDE_MAP;

	assign cmd  = {sh_q[6:0], din};
	assign word = {sh_q, din};
	assign wide = WIDE_MAP[addr_q];
	assign last = cnt_q == (wide ? `SSP_WIDE_LAST : `SSP_NARROW_LAST);
	assign srst_evt = din && ones_q == `SSP_ONES_LAST;

	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q + 5'h01;
		sh_d      = {sh_q[13:0], din};
		rw_d      = rw_q;
		addr_d    = addr_q;
		regs_d    = regs_q;
		rd_word_d = rd_word_q;
		tgl_d     = tgl_q;
		temp_d    = temp_q;
		tack_d    = tack_q;
		ones_d    = din ? ((ones_q == `SSP_ONES_MAX) ? ones_q : ones_q + 6'h01) : 6'h00;
		if (treq_s != tack_q) begin
			temp_d = hold_q;
			tack_d = treq_s;
		end
		if (srst_evt) begin
			state_d = SSP_ST_CMD; // RULE_12
			cnt_d   = 5'h00;
			regs_d  = '{`SSP_CFG_RST, `SSP_CRITICAL_LIMIT_RST, `SSP_HYST_RST,
			            `SSP_THIGH_RST, `SSP_LOWER_LIMIT_RST}; // RULE_13
			tgl_d   = tgl_q ^ 3'b110;
		end else if (cs_n) begin
			state_d = SSP_ST_CMD; // RULE_26
			cnt_d   = 5'h00;
		end else begin
			unique case (state_q)
				SSP_ST_CMD: begin
					if (cnt_q == `SSP_CMD_LAST) begin
						state_d = SSP_ST_DATA;
						cnt_d   = 5'h00;
						rw_d    = cmd[`SSP_CMD_RW]; // RULE_03
						addr_d  = cmd[`SSP_CMD_AHI:`SSP_CMD_ALO]; // RULE_04
						if (cmd[`SSP_CMD_RW]) begin
							tgl_d[0] = ~tgl_q[0]; // RULE_19
							unique case (addr_d)
								`SSP_ADDR_STATUS: rd_word_d = {1'b0, sync_s[2:0], 12'h000};
								`SSP_ADDR_CONFIG: rd_word_d = {regs_q.config_r, 8'h00};
								`SSP_ADDR_TEMP:   rd_word_d = temp_q;
								`SSP_ADDR_ID:     rd_word_d = {ID_CODE, 8'h00};
								`SSP_ADDR_CRITICAL_LIMIT:  rd_word_d = regs_q.critical_limit;
								`SSP_ADDR_HYST:   rd_word_d = {regs_q.hysteresis_amount, 8'h00};
								`SSP_ADDR_THIGH:  rd_word_d = regs_q.upper_limit;
								`SSP_ADDR_LOWER_LIMIT:   rd_word_d = regs_q.lower_limit;
							endcase
						end
					end
				end
				SSP_ST_DATA: begin
					if (last) begin
						state_d = SSP_ST_CMD; // RULE_10
						cnt_d   = 5'h00;
						if (!rw_q) begin
							tgl_d[1] = ~tgl_q[1];
							unique case (addr_q) // RULE_05
								`SSP_ADDR_CONFIG: regs_d.config_r          = word[7:0];
								`SSP_ADDR_CRITICAL_LIMIT:  regs_d.critical_limit    = word;
								`SSP_ADDR_HYST:   regs_d.hysteresis_amount = word[7:0];
								`SSP_ADDR_THIGH:  regs_d.upper_limit       = word;
								`SSP_ADDR_LOWER_LIMIT:   regs_d.lower_limit       = word;
								default:          regs_d                   = regs_q;
							endcase
						end
					end
				end
			endcase
		end
	end

	// cs_n rise ends a cut frame even while sclk stands parked
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			state_q <= SSP_ST_CMD; // RULE_26
			cnt_q   <= 5'h00;
		end else if (srst_s) begin
			state_q <= SSP_ST_CMD;
			cnt_q   <= 5'h00;
		end else begin
			state_q <= state_d; // RULE_22
			cnt_q   <= cnt_d;
		end
	end

	// sampling on rising sclk
	always_ff @(posedge sclk) begin
		if (srst_s) begin
			sh_q      <= 15'h0000;
			rw_q      <= 1'b0;
			addr_q    <= 3'h0;
			ones_q    <= 6'h00;
			regs_q    <= '{`SSP_CFG_RST, `SSP_CRITICAL_LIMIT_RST, `SSP_HYST_RST,
			               `SSP_THIGH_RST, `SSP_LOWER_LIMIT_RST};
			temp_q    <= 16'h0000;
			rd_word_q <= 16'h0000;
			tack_q    <= 1'b0;
			tgl_q     <= 3'h0;
		end else begin
			sh_q      <= sh_d;
			rw_q      <= rw_d;
			addr_q    <= addr_d;
			ones_q    <= ones_d;
			regs_q    <= regs_d;
			temp_q    <= temp_d;
			rd_word_q <= rd_word_d;
			tack_q    <= tack_d;
			tgl_q     <= tgl_d;
		end
	end

	// launching on falling sclk; narrow words sit left-aligned
	always_ff @(negedge sclk) begin
		if (srst_s)
			out_sh_q <= 16'h0000;
		else if (state_q == SSP_ST_DATA && rw_q && cnt_q == 5'h00)
			out_sh_q <= rd_word_q; // RULE_07
		else
			out_sh_q <= {out_sh_q[14:0], 1'b0}; // RULE_22
	end

	assign dout    = out_sh_q[15];
	// enable drops at once on cs_n rise and is set only in the data phase of a read
	assign dout_oe = !cs_n && state_q == SSP_ST_DATA && rw_q; // RULE_09

	// system domain
	ssp_sync #(.W(4)) u_sync_c (
		.clk (clk),
		.d   ({tgl_q, tack_q}),
		.q   ({tgl_c, tack_c})
	);
	assign rd_evt     = tgl_c[0] ^ tgl_p_q[0];
	assign cfg_evt    = tgl_c[1] ^ tgl_p_q[1];
	assign srst_evt_c = tgl_c[2] ^ tgl_p_q[2];
	assign shdn       = cfg_c_q.config_r[`SSP_CFG_OPHI:`SSP_CFG_OPLO] == `SSP_OP_SHDN;
	assign cmp_mode   = cfg_c_q.config_r[`SSP_CFG_CMPMODE]; // RULE_16

	always_comb begin
		logic signed [16:0] t, hy, hi, lo, cr;
		logic [2:0] up;
		up = 3'h0;
		t  = {temp_value[15], temp_value}; // RULE_25
		hy = 17'(cfg_c_q.hysteresis_amount[3:0]) << `SSP_HYST_SHIFT; // RULE_23
		hi = {cfg_c_q.upper_limit[15], cfg_c_q.upper_limit};
		lo = {cfg_c_q.lower_limit[15], cfg_c_q.lower_limit};
		cr = {cfg_c_q.critical_limit[15], cfg_c_q.critical_limit};
		cfg_c_d  = cfg_evt ? regs_q : cfg_c_q; // bundle held stable by the link side
		meas_d   = temp_valid ? temp_value : meas_q;
		hold_d   = hold_q;
		treq_d   = treq_q;
		if (tack_c == treq_q) begin
			hold_d = meas_q;
			treq_d = ~treq_q;
		end
		cmp_d    = cmp_q;
		shdn_p_d = shdn;
		if (temp_valid && !shdn) begin
			if (t > cr) cmp_d[2] = 1'b1; // RULE_24
			else if (t < cr - hy) cmp_d[2] = 1'b0;
			if (t > hi) cmp_d[1] = 1'b1; // RULE_15
			else if (t < hi - hy) cmp_d[1] = 1'b0; // RULE_17
			if (t < lo) cmp_d[0] = 1'b1;
			else if (t > lo + hy) cmp_d[0] = 1'b0;
		end
		up    = cmp_d & ~cmp_q;
		int_d = int_q;
		if (rd_evt || (shdn && !shdn_p_q)) int_d = 2'b00; // RULE_19 RULE_20
		if (up[2]) int_d[1] = 1'b1; // set wins over clear
		if (up[1] || up[0]) int_d[0] = 1'b1;
		if (srst_evt_c) begin
			cmp_d = 3'h0;
			int_d = 2'b00;
		end
		// comparator outputs stay put in shutdown since cmp_q freezes
		alarm_d = cmp_mode ? (cmp_d[1] || cmp_d[0]) : int_d[0]; // RULE_18
		crit_d  = cmp_mode ? cmp_d[2] : int_d[1]; // RULE_25
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_c_q  <= '{`SSP_CFG_RST, `SSP_CRITICAL_LIMIT_RST, `SSP_HYST_RST,
			             `SSP_THIGH_RST, `SSP_LOWER_LIMIT_RST};
			tgl_p_q  <= 3'h0;
			hold_q   <= 16'h0000;
			meas_q   <= 16'h0000;
			treq_q   <= 1'b0;
			cmp_q    <= 3'h0;
			int_q    <= 2'b00;
			shdn_p_q <= 1'b0;
			alarm_q  <= 1'b0;
			crit_q   <= 1'b0;
		end else begin
			cfg_c_q  <= cfg_c_d;
			tgl_p_q  <= tgl_c;
			hold_q   <= hold_d;
			meas_q   <= meas_d;
			treq_q   <= treq_d;
			cmp_q    <= cmp_d;
			int_q    <= int_d;
			shdn_p_q <= shdn_p_d;
			alarm_q  <= alarm_d;
			crit_q   <= crit_d;
		end
	end

	assign alarm_out          = alarm_q;
	assign critical_alarm_out = crit_q;

	// link side checks
	sequence s_cmd_done;
		state_q == SSP_ST_CMD && cnt_q == `SSP_CMD_LAST && !cs_n && !srst_evt;
	endsequence

	property p_rw_bit;
		@(posedge sclk) disable iff (srst_s)
		s_cmd_done |=> state_q == SSP_ST_DATA && rw_q == $past(sh_q[5]);
	endproperty
	a_rw_bit: assert property (p_rw_bit) else $error("rw bit not taken"); // RULE_03

	property p_addr;
		@(posedge sclk) disable iff (srst_s)
		s_cmd_done |=> addr_q == $past(sh_q[4:2]) && cnt_q == 5'h00;
	endproperty
	a_addr: assert property (p_addr) else $error("address not taken"); // RULE_04

	property p_write_lower_limit;
		@(posedge sclk) disable iff (srst_s)
		state_q == SSP_ST_DATA && !rw_q && addr_q == `SSP_ADDR_LOWER_LIMIT && last && !cs_n && !srst_evt
		|=> regs_q.lower_limit == $past(word) && state_q == SSP_ST_CMD;
	endproperty
	a_write_lower_limit: assert property (p_write_lower_limit) else $error("write lost"); // RULE_05

	property p_ones_reset;
		@(posedge sclk) disable iff (srst_s)
		din && ones_q == `SSP_ONES_LAST |=> state_q == SSP_ST_CMD && cnt_q == 5'h00
		&& regs_q.critical_limit == `SSP_CRITICAL_LIMIT_RST && regs_q.config_r == `SSP_CFG_RST;
	endproperty
	a_ones_reset: assert property (p_ones_reset) else $error("serial reset failed"); // RULE_12

	property p_abort;
		@(posedge sclk) disable iff (srst_s)
		cs_n && !srst_evt |=> state_q == SSP_ST_CMD && cnt_q == 5'h00 && $stable(regs_q);
	endproperty
	a_abort: assert property (p_abort) else $error("abort changed state"); // RULE_26

	property p_read_load;
		@(negedge sclk) disable iff (srst_s)
		state_q == SSP_ST_DATA && rw_q && cnt_q == 5'h00 |=> out_sh_q == $past(rd_word_q);
	endproperty
	a_read_load: assert property (p_read_load) else $error("read word not launched"); // RULE_07

	// system side checks
	function automatic logic up_none();
		return (cmp_d & ~cmp_q) == 3'h0;
	endfunction

	property p_int_clear;
		@(posedge clk) disable iff (rst)
		!cmp_mode && rd_evt && !cfg_evt && up_none() |=> !alarm_q && !crit_q;
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("read did not clear alarm"); // RULE_19

	property p_cmp_high;
		@(posedge clk) disable iff (rst)
		cmp_mode && !cfg_evt && !srst_evt_c && temp_valid && !shdn
		&& $signed(temp_value) > $signed(cfg_c_q.upper_limit) |=> alarm_q;
	endproperty
	a_cmp_high: assert property (p_cmp_high) else $error("over limit not flagged"); // RULE_15

	property p_crit;
		@(posedge clk) disable iff (rst)
		cmp_mode && !cfg_evt && !srst_evt_c && temp_valid && !shdn
		&& $signed(temp_value) > $signed(cfg_c_q.critical_limit) |=> crit_q;
	endproperty
	a_crit: assert property (p_crit) else $error("critical not flagged"); // RULE_24

	property p_shdn_clear;
		@(posedge clk) disable iff (rst)
		!cmp_mode && !cfg_evt && shdn && !shdn_p_q |=> !alarm_q ##1 !alarm_q;
	endproperty
	a_shdn_clear: assert property (p_shdn_clear) else $error("shutdown kept alarm"); // RULE_20
endmodule
`default_nettype wire

/* File: ssp_master.sv */
/*
 * Behavioural SPI master facing the sensor port: mode 3, 80 ns sclk.
 * Assumes the bench calls one task at a time; sclk stands high between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module ssp_master (
	// link pins
	output var  logic sclk,
	output var  logic cs_n,
	output var  logic din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end
	// bare clocks, din held, cs_n untouched; 7 ns skew keeps edges off clk
	task automatic clocks(input int n, input logic v);
		#7;
		for (int i = 0; i < n; i++) begin
			#40 sclk = 1'b0;
			din = v;
			#40 sclk = 1'b1;
		end
	endtask
	// command then nb data bits; dout taken at each data rising edge
	task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, input int nb, input logic hold,
		output logic [15:0] rd, output logic oe);
		rd = 16'h0000;
		oe = 1'b1;
		#7 cs_n = 1'b0;
		for (int i = 0; i < 8 + nb; i++) begin
			#40 sclk = 1'b0;
			din = (i < 8) ? cmd[7 - i] : wd[nb + 7 - i];
			#40 sclk = 1'b1;
			if (i >= 8) begin
				rd = {rd[14:0], dout};
				oe = oe & dout_oe;
			end
		end
		// released line must not show a stale bit
		#40 din = ~din;
		if (!hold) cs_n = 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: test_ssp_sensor_port.sv */
/*
 * Self-checking bench of the sensor serial port and its alarms.
 * Assumes ssp_master drives the link; temperatures are pushed on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_ssp_sensor_port
	import ssp_pkg::*;
;
	localparam logic [7:0] ID_CODE = 8'hA6; // arbitrary value
	localparam logic [7:0] WIDE    = `SSP_WIDE_MAP;
	logic        clk;
	logic        rst;
	logic        temp_valid;
	logic [15:0] temp_value;
	logic [15:0] rdv;
	logic        oev;
	int          failures;
	int          cmp_count;
	int          cyc;
	wire logic   sclk;
	wire logic   cs_n;
	wire logic   din;
	wire logic   dout;
	wire logic   dout_oe;
	wire logic   alarm_out;
	wire logic   critical_alarm_out;

	ssp_sensor_port #(.ID_CODE(ID_CODE)) ssp_sensor_port_i (.clk(clk), .rst(rst), .temp_value(temp_value),
		.temp_valid(temp_valid), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.alarm_out(alarm_out), .critical_alarm_out(critical_alarm_out));
	ssp_master ssp_master_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// long enough for two 500 us waits plus all frames
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			$display("Error timeout expected done seen hang");
			close_out();
		end
	end

	task automatic xfer(input logic r, input logic [2:0] a, input logic [15:0] wd, input int nb, input logic hold = 1'b0);
		ssp_master_i.frame({1'b0, r, a, 3'b000}, wd, nb, hold, rdv, oev);
		repeat (10) @(negedge clk);
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [15:0] e, input logic hold = 1'b0);
		xfer(1'b1, a, 16'h0000, WIDE[a] ? 16 : 8, hold);
		`CHK("read data", e, rdv)
		`CHK("dout_oe in read", 1'b1, oev)
	endtask
	task automatic temp(input logic [15:0] t);
		@(negedge clk);
		temp_value = t;
		temp_valid = 1'b1;
		@(negedge clk);
		temp_valid = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic alarms(input logic a, input logic c);
		`CHK("alarm_out", a, alarm_out)
		`CHK("critical_alarm_out", c, critical_alarm_out)
	endtask

	task automatic t_bringup();
		ssp_master_i.clocks(32, 1'b1);
		#500000;
		rd_chk(3'h3, ID_CODE);
		rd_chk(3'h3, ID_CODE);
		rd_chk(3'h1, 16'h0000);
		rd_chk(3'h4, 16'h4980);
		rd_chk(3'h5, 16'h0005);
		rd_chk(3'h6, 16'h2000);
		rd_chk(3'h7, 16'h0500);
		$display("bringup done");
	endtask

	task automatic t_write();
		xfer(1'b0, 3'h7, 16'h1234, 16);
		rd_chk(3'h7, 16'h1234);
		xfer(1'b0, 3'h5, 16'h000A, 8);
		rd_chk(3'h5, 16'h000A);
		xfer(1'b0, 3'h3, 16'h00FF, 8);
		rd_chk(3'h3, ID_CODE);
		xfer(1'b0, 3'h6, 16'h1111, 8);
		rd_chk(3'h6, 16'h2000);
		xfer(1'b0, 3'h7, 16'h0500, 16);
		xfer(1'b0, 3'h5, 16'h0005, 8);
		$display("write done");
	endtask

	task automatic t_3wire();
		rd_chk(3'h3, ID_CODE, 1'b1);
		xfer(1'b0, 3'h7, 16'h0600, 16, 1'b1);
		rd_chk(3'h7, 16'h0600, 1'b1);
		xfer(1'b0, 3'h7, 16'h0500, 16);
		`CHK("dout_oe idle", 1'b0, dout_oe)
		$display("3-wire done");
	endtask

	task automatic t_sreset();
		xfer(1'b0, 3'h6, 16'h1000, 16);
		xfer(1'b0, 3'h1, 16'h0010, 8);
		ssp_master_i.clocks(32, 1'b1);
		#500000;
		rd_chk(3'h6, 16'h2000);
		rd_chk(3'h1, 16'h0000);
		$display("serial reset done");
	endtask

	task automatic t_int();
		temp(16'h2100);
		alarms(1'b1, 1'b0);
		rd_chk(3'h3, ID_CODE);
		alarms(1'b0, 1'b0);
		temp(16'h2100);
		alarms(1'b0, 1'b0);
		temp(16'h1000);
		temp(16'h2100);
		alarms(1'b1, 1'b0);
		xfer(1'b0, 3'h1, 16'h0060, 8);
		alarms(1'b0, 1'b0);
		xfer(1'b0, 3'h1, 16'h0000, 8);
		temp(16'h1000);
		temp(16'hFF00);
		alarms(1'b1, 1'b0);
		rd_chk(3'h1, 16'h0000);
		temp(16'h1000);
		temp(16'h4A00);
		alarms(1'b1, 1'b1);
		rd_chk(3'h1, 16'h0000);
		alarms(1'b0, 1'b0);
		temp(16'h1000);
		$display("interrupt mode done");
	endtask

	// hysteresis 5 degrees: upper band edge 0x1D80, lower 0x0780
	task automatic t_cmp();
		xfer(1'b0, 3'h1, 16'h0010, 8);
		temp(16'h2100);
		alarms(1'b1, 1'b0);
		temp(16'h1F00);
		alarms(1'b1, 1'b0);
		xfer(1'b0, 3'h1, 16'h0070, 8);
		rd_chk(3'h1, 16'h0070);
		alarms(1'b1, 1'b0);
		xfer(1'b0, 3'h1, 16'h0010, 8);
		temp(16'h1D00);
		alarms(1'b0, 1'b0);
		temp(16'h0400);
		alarms(1'b1, 1'b0);
		rd_chk(3'h0, 16'h0010);
		rd_chk(3'h2, 16'h0400);
		temp(16'h0700);
		alarms(1'b1, 1'b0);
		temp(16'h0800);
		alarms(1'b0, 1'b0);
		xfer(1'b0, 3'h1, 16'h0000, 8);
		$display("comparator mode done");
	endtask

	initial begin
		rst = 1'b1;
		temp_valid = 1'b0;
		temp_value = 16'h0000;
		failures = 0;
		cmp_count = 0;
		cyc = 0;
		// link side sees reset only while sclk runs
		fork
			repeat (16) @(negedge clk);
			ssp_master_i.clocks(8, 1'b0);
		join
		rst = 1'b0;
		ssp_master_i.clocks(4, 1'b0);
		t_bringup();
		t_write();
		t_3wire();
		t_int();
		t_cmp();
		t_sreset();
		close_out();
	end
endmodule
`default_nettype wire
